/* File: arlt_timer.sv */
// arlt_timer: 16-bit / dual 8-bit auto-reload timer with oscillator capture
// assumes one 100 MHz clock, synchronous reset, classic wishbone master;
// ext_osc_i and slow_osc_i are asynchronous pins
`timescale 1ns/1ps

// What this block does
// - two 8-bit halves; split select picks one 16-bit or two 8-bit timers
// - counting clocks: system clock, system clock /12, external osc /8
// - external osc /8 is synchronised to the system clock before use
// - 16-bit wrap from FFFF loads reload pair and sets high overflow flag
// - 16-bit mode: every overflow requests interrupt when timer irq enabled
// - 16-bit mode: low byte wrap also interrupts when low irq enable set
// - split mode: each half reloads from its own reload byte
// - split mode: run control gates only the high half
// - split mode: fast select gives system clock, else external select
// - split mode: high wrap sets high flag, low wrap sets low flag
// - split mode: high overflow interrupts; with low enable either half
// - flags are never cleared by hardware; software clears them by writing
// - slow osc falling edge copies count to reload pair, sets high flag
// - capture mode clock from low fast select and external select
// - low half wrap sets the low flag in every mode
// - 16-bit mode counts only while run control is 1; reset stops it
module arlt_timer
   import arlt_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        ext_osc_i,
   input  wire logic        slow_osc_i,
   output logic             irq_o
);

   // ==========================================================
   // state
   arlt_ctrl_type ctrl_q;
   logic       high_fast_q;
   logic       low_fast_q;
   logic       timer_irq_en_q;
   logic [7:0] count_low_half_q;
   logic [7:0] count_high_half_q;
   logic [7:0] reload_low_byte_q;
   logic [7:0] reload_high_byte_q;
   logic [1:0] ext_sync_q;
   logic       ext_last_q;
   logic [2:0] ext_div_q;
   logic [1:0] slow_sync_q;
   logic       slow_last_q;
   logic [3:0] div12_q;
   logic       ack_q;
   logic [31:0] dat_q;
   logic       irq_q;

   // decoded strobes
   logic       wr_en;
   logic       tick_div12;
   logic       tick_ext8;
   logic       tick_low;
   logic       tick_high;
   logic       adv_low;
   logic       adv_high;
   logic       low_wrap;
   logic       high_wrap;
   logic       full_wrap;
   logic       cap_evt;
   logic       set_high;
   logic       set_low;

   // ==========================================================
   // clock source choice for one half
   function automatic logic pick_tick(input logic fast, input logic xclk,
                                      input logic t12, input logic t8);
      if (fast) begin
         pick_tick = 1'b1;
      end else if (xclk) begin
         pick_tick = t8;
      end else begin
         pick_tick = t12;
      end
   endfunction

   // byte-lane write of a register field
   function automatic logic wr_hit(input logic [4:0] adr,
                                   input logic [4:0] ofs,
                                   input logic       en,
                                   input logic       lane);
      wr_hit = en && lane && (adr == ofs);
   endfunction

   // ==========================================================
   // pin synchronisers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_sync_q  <= 2'h0;
         slow_sync_q <= 2'h0;
      end else begin
         ext_sync_q  <= {ext_sync_q[0], ext_osc_i};
         slow_sync_q <= {slow_sync_q[0], slow_osc_i};
      end
   end

   // ==========================================================
   // prescalers: system /12 and synchronised external /8
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div12_q <= 4'h0;
      end else if (div12_q == ARLT_DIV12_LAST) begin
         div12_q <= 4'h0;
      end else begin
         div12_q <= div12_q + 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_last_q <= 1'b0;
         ext_div_q  <= 3'h0;
      end else begin
         ext_last_q <= ext_sync_q[1];
         if (ext_sync_q[1] && !ext_last_q) begin
            ext_div_q <= ext_div_q + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slow_last_q <= 1'b0;
      end else begin
         slow_last_q <= slow_sync_q[1];
      end
   end

   // ==========================================================
   // counting enables and wrap detection
   always_comb begin
      tick_div12 = (div12_q == ARLT_DIV12_LAST);
      tick_ext8  = ext_sync_q[1] && !ext_last_q
                   && (ext_div_q == ARLT_DIV8_LAST);
      // low select drives the low half and the whole 16-bit counter
      tick_low   = pick_tick(low_fast_q, ctrl_q.xclk,
                             tick_div12, tick_ext8);
      tick_high  = pick_tick(high_fast_q, ctrl_q.xclk,
                             tick_div12, tick_ext8);
      if (ctrl_q.split) begin
         adv_low  = tick_low;
         adv_high = tick_high && ctrl_q.run;
      end else begin
         adv_low  = tick_low && ctrl_q.run;
         adv_high = adv_low;
      end
      low_wrap  = adv_low && (count_low_half_q == ARLT_BYTE_MAX);
      high_wrap = adv_high && (count_high_half_q == ARLT_BYTE_MAX);
      full_wrap = !ctrl_q.split && low_wrap
                  && (count_high_half_q == ARLT_BYTE_MAX);
      cap_evt   = ctrl_q.cap_en && slow_last_q && !slow_sync_q[1];
      set_low   = low_wrap;
      set_high  = ctrl_q.split ? high_wrap : full_wrap;
      set_high  = set_high || cap_evt;
      wr_en     = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
   end

   // ==========================================================
   // control register: flags set by hardware win over a clearing write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= '0;
      end else begin
         if (wr_hit(wb_adr_i, ARLT_OFS_CTRL, wr_en, wb_sel_i[0])) begin
            ctrl_q.high_ovf   <= wb_dat_i[ARLT_BIT_HOVF] || set_high;
            ctrl_q.low_ovf    <= wb_dat_i[ARLT_BIT_LOVF] || set_low;
            ctrl_q.low_irq_en <= wb_dat_i[ARLT_BIT_LIEN];
            ctrl_q.cap_en     <= wb_dat_i[ARLT_BIT_CAPEN];
            ctrl_q.split      <= wb_dat_i[ARLT_BIT_SPLIT];
            ctrl_q.run        <= wb_dat_i[ARLT_BIT_RUN];
            ctrl_q.xclk       <= wb_dat_i[ARLT_BIT_XCLK];
         end else begin
            ctrl_q.high_ovf <= ctrl_q.high_ovf || set_high;
            ctrl_q.low_ovf  <= ctrl_q.low_ovf || set_low;
         end
      end
   end

   // clock select and interrupt enable registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         high_fast_q    <= 1'b0;
         low_fast_q     <= 1'b0;
         timer_irq_en_q <= 1'b0;
      end else begin
         if (wr_hit(wb_adr_i, ARLT_OFS_CLKCTL, wr_en, wb_sel_i[0])) begin
            high_fast_q <= wb_dat_i[ARLT_BIT_HFAST];
            low_fast_q  <= wb_dat_i[ARLT_BIT_LFAST];
         end
         if (wr_hit(wb_adr_i, ARLT_OFS_IEN, wr_en, wb_sel_i[0])) begin
            timer_irq_en_q <= wb_dat_i[ARLT_BIT_TIEN];
         end
      end
   end

   // ==========================================================
   // low half: software write wins, otherwise count and reload
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_low_half_q <= ARLT_RST_BYTE;
      end else if (wr_hit(wb_adr_i, ARLT_OFS_CNTL, wr_en, wb_sel_i[0])) begin
         count_low_half_q <= wb_dat_i[7:0];
      end else if (full_wrap) begin
         count_low_half_q <= reload_low_byte_q;
      end else if (low_wrap && ctrl_q.split) begin
         count_low_half_q <= reload_low_byte_q;
      end else if (adv_low) begin
         count_low_half_q <= count_low_half_q + 8'h01;
      end
   end

   // high half: in 16-bit mode it steps on the low byte carry
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_high_half_q <= ARLT_RST_BYTE;
      end else if (wr_hit(wb_adr_i, ARLT_OFS_CNTH, wr_en, wb_sel_i[0])) begin
         count_high_half_q <= wb_dat_i[7:0];
      end else if (full_wrap) begin
         count_high_half_q <= reload_high_byte_q;
      end else if (ctrl_q.split) begin
         if (high_wrap) begin
            count_high_half_q <= reload_high_byte_q;
         end else if (adv_high) begin
            count_high_half_q <= count_high_half_q + 8'h01;
         end
      end else if (low_wrap) begin
         count_high_half_q <= count_high_half_q + 8'h01;
      end
   end

   // reload pair: a capture overrides a software write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reload_low_byte_q  <= ARLT_RST_BYTE;
         reload_high_byte_q <= ARLT_RST_BYTE;
      end else if (cap_evt) begin
         reload_low_byte_q  <= count_low_half_q;
         reload_high_byte_q <= count_high_half_q;
      end else begin
         if (wr_hit(wb_adr_i, ARLT_OFS_RLL, wr_en, wb_sel_i[0])) begin
            reload_low_byte_q <= wb_dat_i[7:0];
         end
         if (wr_hit(wb_adr_i, ARLT_OFS_RLH, wr_en, wb_sel_i[0])) begin
            reload_high_byte_q <= wb_dat_i[7:0];
         end
      end
   end

   // ==========================================================
   // interrupt request, level while an enabled flag stands
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= timer_irq_en_q
                  && (ctrl_q.high_ovf
                      || (ctrl_q.low_irq_en && ctrl_q.low_ovf));
      end
   end

   // ==========================================================
   // wishbone slave: one wait state, ack for one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= ARLT_RST_WORD;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
         dat_q <= ARLT_RST_WORD;
         case (wb_adr_i)
            ARLT_OFS_CTRL: begin
               dat_q[ARLT_BIT_HOVF]  <= ctrl_q.high_ovf;
               dat_q[ARLT_BIT_LOVF]  <= ctrl_q.low_ovf;
               dat_q[ARLT_BIT_LIEN]  <= ctrl_q.low_irq_en;
               dat_q[ARLT_BIT_CAPEN] <= ctrl_q.cap_en;
               dat_q[ARLT_BIT_SPLIT] <= ctrl_q.split;
               dat_q[ARLT_BIT_RUN]   <= ctrl_q.run;
               dat_q[ARLT_BIT_XCLK]  <= ctrl_q.xclk;
            end
            ARLT_OFS_CLKCTL: begin
               dat_q[ARLT_BIT_HFAST] <= high_fast_q;
               dat_q[ARLT_BIT_LFAST] <= low_fast_q;
            end
            ARLT_OFS_CNTL:  dat_q[7:0] <= count_low_half_q;
            ARLT_OFS_CNTH:  dat_q[7:0] <= count_high_half_q;
            ARLT_OFS_RLL:   dat_q[7:0] <= reload_low_byte_q;
            ARLT_OFS_RLH:   dat_q[7:0] <= reload_high_byte_q;
            ARLT_OFS_IEN:   dat_q[ARLT_BIT_TIEN] <= timer_irq_en_q;
            default:        dat_q <= ARLT_RST_WORD; // unmapped reads zero
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign irq_o    = irq_q;

endmodule

/* File: arlt_pkg.sv */
// arlt_pkg: constants and types for the auto-reload timer with capture
// assumes a 32-bit classic wishbone bus with word-aligned byte addresses
package arlt_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [4:0] ARLT_OFS_CTRL   = 5'h00; // timer_control_reg
   localparam logic [4:0] ARLT_OFS_CLKCTL = 5'h04; // clock_control_reg
   localparam logic [4:0] ARLT_OFS_CNTL   = 5'h08; // count_low_half
   localparam logic [4:0] ARLT_OFS_CNTH   = 5'h0C; // count_high_half
   localparam logic [4:0] ARLT_OFS_RLL    = 5'h10; // reload_low_byte
   localparam logic [4:0] ARLT_OFS_RLH    = 5'h14; // reload_high_byte
   localparam logic [4:0] ARLT_OFS_IEN    = 5'h18; // timer interrupt enable

   // ==========================================================
   // timer_control_reg field positions
   localparam int ARLT_BIT_HOVF  = 7;
   localparam int ARLT_BIT_LOVF  = 6;
   localparam int ARLT_BIT_LIEN  = 5;
   localparam int ARLT_BIT_CAPEN = 4;
   localparam int ARLT_BIT_SPLIT = 3;
   localparam int ARLT_BIT_RUN   = 2;
   localparam int ARLT_BIT_XCLK  = 0;
   // clock_control_reg field positions
   localparam int ARLT_BIT_HFAST = 5;
   localparam int ARLT_BIT_LFAST = 4;
   // interrupt enable register field position
   localparam int ARLT_BIT_TIEN  = 0;

   // ==========================================================
   // reset values
   localparam logic [7:0] ARLT_RST_BYTE = 8'h00;
   localparam logic [31:0] ARLT_RST_WORD = 32'h0000_0000;

   // ==========================================================
   // timing counts
   localparam logic [3:0] ARLT_DIV12_LAST = 4'hB; // system clock / 12
   localparam logic [2:0] ARLT_DIV8_LAST  = 3'h7; // external osc / 8
   localparam logic [7:0] ARLT_BYTE_MAX   = 8'hFF;

   // control bits carried as one group
   typedef struct packed {
      logic high_ovf;
      logic low_ovf;
      logic low_irq_en;
      logic cap_en;
      logic split;
      logic run;
      logic xclk;
   } arlt_ctrl_type;

endpackage

/* File: arlt_timer_sva.sv */
// arlt_timer_sva: port checks of the timer's bus slave and interrupt
// assumes one clock domain; bound to every arlt_timer instance
`timescale 1ns/1ps
module arlt_timer_sva
   import arlt_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [4:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        ext_osc_i,
   input wire logic        slow_osc_i,
   input wire logic        irq_o
);
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ==========================================================
   // bus answer timing
   property p_ack_wait;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_wait: assert property (p_ack_wait)
      else $error("bus request not answered after one wait cycle");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack stood longer than one cycle");
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without a request");
   // ==========================================================
   // read data contents
   property p_upper_zero;
      wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("read data upper bits not zero");
   property p_unused_bit;
      wb_ack_o && !wb_we_i && wb_adr_i == ARLT_OFS_CTRL |-> !wb_dat_o[1];
   endproperty
   a_unused_bit: assert property (p_unused_bit)
      else $error("unused control bit read as one");
   property p_unmapped;
      wb_ack_o && !wb_we_i && wb_adr_i == 5'h1C |-> wb_dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read gave nonzero data");
   // ==========================================================
   // reset and interrupt behaviour
   property p_reset_quiet;
      $past(rst_i) |-> !wb_ack_o && !irq_o;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("ack or irq active right after reset");
   property p_irq_fall;
      $fell(irq_o) |-> $past(wb_ack_o && wb_we_i, 2) || $past(rst_i, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("irq dropped without a register write");
endmodule

bind arlt_timer arlt_timer_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_osc_i(ext_osc_i),
   .slow_osc_i(slow_osc_i), .irq_o(irq_o));

/* File: arlt_timer_tb.sv */
// arlt_timer_tb: self-checking bench for the auto-reload timer
// assumes the slave acks each classic cycle after one wait cycle
`timescale 1ns/1ps
module arlt_timer_tb;
   import arlt_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, ack, irq, slow;
   logic        ext = 1'h0;
   logic [1:0]  ext_div = 2'h0;
   logic [4:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat, dato;
   logic [7:0]  rd, d;
   int          err_count, checks, seed;
   arlt_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .ext_osc_i(ext),
      .slow_osc_i(slow), .irq_o(irq));
   // ==========================================================
   // system clock and a free external oscillator at a quarter rate
   initial begin
      clk_i = 1'h0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      ext_div <= ext_div + 2'h1;
      ext <= ext_div[1];
   end
   // ==========================================================
   // verdict, comparisons and bus cycles
   task automatic results();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %b seen %b", nm, e, g);
      end
   endtask
   // count expectation with one tick of slack for pipeline phase
   function automatic logic [7:0] near(input logic [7:0] g, input int e);
      if (g >= e - 1 && g <= e + 1)
         return e[7:0];
      return g;
   endfunction
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [7:0] v, input logic s);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      sel <= {3'h0, s};
      dat <= {24'h0, v};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'h1 && n < 20);
      rd = dato[7:0];
      cyc <= 1'h0;
      stb <= 1'h0;
      if (n >= 20) begin
         err_count++;
         results();
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      bus(1'h1, a, v, 1'h1);
   endtask
   task automatic rc(input string nm, input logic [4:0] a,
                     input logic [7:0] e);
      bus(1'h0, a, 8'h00, 1'h1);
      chk(nm, e, rd);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      seed = 32'h99B39490;
      {err_count, checks} = 0;
      {rst_i, cyc, stb, we, slow} = 5'h10;
      {adr, sel, dat} = 41'h0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'h0;
      for (int a = 0; a < 32; a += 4)
         rc("reset", 5'(a), ARLT_RST_BYTE);
      wr(ARLT_OFS_CTRL, 8'h02);
      rc("unused bit", ARLT_OFS_CTRL, 8'h00);
      // random reload bytes; lane-masked writes must be ignored
      for (int i = 0; i < 6; i++) begin
         d = 8'($random(seed));
         wr(ARLT_OFS_RLL, d);
         bus(1'h1, ARLT_OFS_RLH, ~d, 1'h0);
         rc("reload low", ARLT_OFS_RLL, d);
         rc("reload high", ARLT_OFS_RLH, 8'h00);
      end
      // stopped 16-bit timer on the fast clock holds its count
      wr(ARLT_OFS_CLKCTL, 8'h10);
      wr(ARLT_OFS_CNTL, 8'h5A);
      repeat (30) @(posedge clk_i);
      rc("stopped count", ARLT_OFS_CNTL, 8'h5A);
      // 16-bit wrap reloads the pair and sets both flags
      wr(ARLT_OFS_IEN, 8'h01);
      wr(ARLT_OFS_RLH, 8'h12);
      wr(ARLT_OFS_RLL, 8'h00);
      wr(ARLT_OFS_CNTH, 8'hFF);
      wr(ARLT_OFS_CNTL, 8'hF8);
      wr(ARLT_OFS_CTRL, 8'h04);
      repeat (20) @(posedge clk_i);
      rc("wrap flags", ARLT_OFS_CTRL, 8'hC4);
      chk1("irq wrap", 1'h1, irq);
      wr(ARLT_OFS_CTRL, 8'h00);
      rc("reloaded high", ARLT_OFS_CNTH, 8'h12);
      repeat (3) @(posedge clk_i);
      chk1("irq cleared", 1'h0, irq);
      // low byte wrap in 16-bit mode with the low irq enable
      wr(ARLT_OFS_CNTL, 8'hF0);
      wr(ARLT_OFS_CTRL, 8'h24);
      repeat (30) @(posedge clk_i);
      rc("low flag", ARLT_OFS_CTRL, 8'h64);
      chk1("irq low", 1'h1, irq);
      // split mode: low half runs without run control
      wr(ARLT_OFS_CLKCTL, 8'h30);
      wr(ARLT_OFS_RLL, 8'h80);
      wr(ARLT_OFS_RLH, 8'h40);
      wr(ARLT_OFS_CNTH, 8'hFE);
      wr(ARLT_OFS_CTRL, 8'h28);
      wr(ARLT_OFS_CNTL, 8'hFE);
      repeat (10) @(posedge clk_i);
      rc("split low", ARLT_OFS_CTRL, 8'h68);
      rc("high held", ARLT_OFS_CNTH, 8'hFE);
      bus(1'h0, ARLT_OFS_CNTL, 8'h00, 1'h1);
      chk("low reload", 8'h80, rd & 8'hC0);
      chk1("irq split low", 1'h1, irq);
      wr(ARLT_OFS_CTRL, 8'h0C);
      repeat (10) @(posedge clk_i);
      rc("split high", ARLT_OFS_CTRL, 8'h8C);
      chk1("irq split high", 1'h1, irq);
      bus(1'h0, ARLT_OFS_CNTH, 8'h00, 1'h1);
      chk("high reload", 8'h40, rd & 8'hC0);
      // divided clocks over a fixed window of 120 and 320 cycles
      wr(ARLT_OFS_CTRL, 8'h00);
      wr(ARLT_OFS_CLKCTL, 8'h00);
      for (int x = 0; x < 2; x++) begin
         wr(ARLT_OFS_CNTH, 8'h00);
         wr(ARLT_OFS_CNTL, 8'h00);
         wr(ARLT_OFS_CTRL, 8'(4 + x));
         repeat (x ? 317 : 117) @(posedge clk_i);
         wr(ARLT_OFS_CTRL, 8'(x));
         bus(1'h0, ARLT_OFS_CNTL, 8'h00, 1'h1);
         chk("div ticks", 8'h0A, near(rd, 10));
      end
      // split halves on own clocks: high on /12, low on the fast clock
      wr(ARLT_OFS_CLKCTL, 8'h10);
      wr(ARLT_OFS_CNTH, 8'h00);
      wr(ARLT_OFS_CTRL, 8'h0C);
      repeat (117) @(posedge clk_i);
      wr(ARLT_OFS_CTRL, 8'h08);
      rc("split high slow", ARLT_OFS_CNTH, 8'h0A);
      // capture copies the count on a slow oscillator falling edge
      wr(ARLT_OFS_CLKCTL, 8'h10);
      wr(ARLT_OFS_CNTH, 8'h55);
      wr(ARLT_OFS_CNTL, 8'h00);
      wr(ARLT_OFS_CTRL, 8'h14);
      slow <= 1'h1;
      repeat (10) @(posedge clk_i);
      slow <= 1'h0;
      repeat (10) @(posedge clk_i);
      rc("capture flag", ARLT_OFS_CTRL, 8'h94);
      rc("captured high", ARLT_OFS_RLH, 8'h55);
      chk1("irq capture", 1'h1, irq);
      results();
   end
endmodule
